// file: logic/pad_function_select_regs.vh
// Purpose: register map and field constants for the pad function select mux
// Assumes: 32-bit avalon-mm slave, byte addresses
// Notes:   definitions only
`ifndef PAD_FUNCTION_SELECT_REGS_VH
`define PAD_FUNCTION_SELECT_REGS_VH

`define PFS_ADDR_W          8
`define PFS_OFFSET          8'h24
`define PFS_RESET           32'h0000_0000
`define PFS_SEL_LSB         0
`define PFS_SEL_MSB         2
`define PFS_FORCE_BIT       4
`define PFS_SEL_W           3
`define PFS_NUM_FUNC        8
`define PFS_UNMAPPED_DATA   32'h0000_0000
`define PFS_SEL_RESET       3'h0
`define PFS_FORCE_RESET     1'h0
`define PFS_FIELD_LANE      0

`define FUNC_GPIO_B2L5      3'h0
`define FUNC_TIMER4_CH0     3'h1
`define FUNC_PDM_BS0        3'h2
`define FUNC_DISPLAY_D1     3'h3
`define FUNC_SPI7_DIN       3'h4
`define FUNC_UART6_RX       3'h5
`define FUNC_I2C6_CLOCK     3'h6
`define FUNC_FLEXIO1_CH5    3'h7

`endif

// file: logic/pad_route_decoder.v
// Purpose: one-hot decode of the function-select code into per-function enables
// Assumes: same clock as the register block; registered outputs
// Notes:   input enable per function combines function ownership with the force bit
`timescale 1ns/1ps
`include "pad_function_select_regs.vh"

module pad_route_decoder (
    // clock and reset
    input  wire                       sys_clk_i,
    input  wire                       rst_i,
    // control
    input  wire [`PFS_SEL_W-1:0]      sel_i,
    input  wire                       force_in_i,
    // per-function enables
    output reg  [`PFS_NUM_FUNC-1:0]   owner_o,
    output reg  [`PFS_NUM_FUNC-1:0]   in_en_o
);

    // one-hot view of the code keeps the loop index out of a width compare
    wire [`PFS_NUM_FUNC-1:0] sel_onehot;

    assign sel_onehot = {{(`PFS_NUM_FUNC-1){1'b0}}, 1'b1} << sel_i;

    genvar g;
    generate
        for (g = 0; g < `PFS_NUM_FUNC; g = g + 1) begin : g_func
            always @(posedge sys_clk_i) begin
                if (rst_i) begin
                    owner_o[g] <= 1'b0;
                    in_en_o[g] <= 1'b0;
                end else begin
                    owner_o[g] <= sel_onehot[g];
                    // the forced path reaches every function, not only the owner
                    in_en_o[g] <= sel_onehot[g] | force_in_i;
                end
            end
        end
    endgenerate

endmodule // pad_route_decoder

// file: logic/pad_function_select_mux.v
// Purpose: pad function select register and pad mux for one general-purpose pad
// Assumes: single 100 MHz clock, synchronous active-high reset, avalon-mm slave
// Notes:   pad input is synchronised before it reaches any function;
//          routing lags a register write by two cycles (register, then decoder);
//          each bus access is answered after one wait cycle, so a master that
//          holds its request gets an answer every second cycle;
//          only byte lane 0 can write, since every field sits in it;
//          with the force bit set every function hears the pad, while
//          only the selected function may ever drive it;
//          unmapped reads are answered normally and return zero
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "pad_function_select_regs.vh"

module pad_function_select_mux (
    // clock and reset
    input  wire                      sys_clk_i,
    input  wire                      rst_i,
    // avalon-mm slave
    input  wire [`PFS_ADDR_W-1:0]    avs_address_i,
    input  wire                      avs_read_i,
    input  wire                      avs_write_i,
    input  wire [31:0]               avs_writedata_i,
    input  wire [3:0]                avs_byteenable_i,
    output reg  [31:0]               avs_readdata_o,
    output reg                       avs_waitrequest_o,
    // target pad
    input  wire                      target_pad_i,
    output reg                       target_pad_o,
    output reg                       target_pad_oe_o,
    // function-side drive requests
    input  wire [`PFS_NUM_FUNC-1:0]  func_out_i,
    input  wire [`PFS_NUM_FUNC-1:0]  func_oe_i,
    // function-side received levels, one per function
    output reg                       gpio_bank2_line5_o,
    output reg                       timer4_channel0_o,
    output reg                       pdm_bitstream0_o,
    output reg                       display_data1_o,
    output reg                       spi7_data_in_o,
    output reg                       uart6_receive_o,
    output reg                       i2c6_clock_o,
    output reg                       flexible_io1_channel5_o,
    // state view
    output reg  [`PFS_SEL_W-1:0]     active_function_o,
    output reg                       force_input_path_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register and bus slave
    // every access costs one wait cycle: a request is taken in the idle state
    // and answered in the next, so waitrequest and readdata both leave
    // straight from flip-flops at the price of half the peak bus rate
    localparam BUS_IDLE   = 1'b0;
    localparam BUS_ANSWER = 1'b1;

    reg                      bus_state_reg;
    reg                      bus_state_next;

    reg  [`PFS_SEL_W-1:0]    select_reg;
    reg  [`PFS_SEL_W-1:0]    select_next;
    reg                      force_reg;
    reg                      force_next;

    reg                      waitrequest_next;
    reg  [31:0]              readdata_next;

    wire                     hit;
    wire                     req;
    wire                     wr_take;
    wire                     rd_take;
    wire [31:0]              readback_word;

    assign hit      = (avs_address_i == `PFS_OFFSET);
    assign req      = avs_read_i | avs_write_i;
    // every field lives in byte lane 0, so only that lane gates a write
    assign wr_take  = avs_write_i & hit & avs_byteenable_i[`PFS_FIELD_LANE];
    assign rd_take  = avs_read_i & hit;
    // bits 31-5 and bit 3 are not stored and read back zero
    assign readback_word = {27'h000_0000, force_reg, 1'b0, select_reg};

    always @* begin
        bus_state_next   = bus_state_reg;
        select_next      = select_reg;
        force_next       = force_reg;
        waitrequest_next = 1'b1;
        readdata_next    = avs_readdata_o;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_next   = BUS_ANSWER;
                    waitrequest_next = 1'b0;
                    if (wr_take) begin
                        select_next = avs_writedata_i[`PFS_SEL_MSB:`PFS_SEL_LSB];
                        force_next  = avs_writedata_i[`PFS_FORCE_BIT];
                    end
                    if (rd_take) begin
                        readdata_next = readback_word;
                    end else begin
                        // unmapped reads and all writes still get an answer
                        readdata_next = `PFS_UNMAPPED_DATA;
                    end
                end
            end
            BUS_ANSWER: begin
                // the master lets go on this edge; a request it keeps up is
                // taken again as a new access one cycle later
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus_state_reg     <= BUS_IDLE;
            select_reg        <= `PFS_SEL_RESET;
            force_reg         <= `PFS_FORCE_RESET;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= `PFS_RESET;
        end else begin
            bus_state_reg     <= bus_state_next;
            select_reg        <= select_next;
            force_reg         <= force_next;
            avs_waitrequest_o <= waitrequest_next;
            avs_readdata_o    <= readdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing decode
    // registered, so owner and in_en settle one edge after the field and
    // the pad never sees a half-decoded code while the field changes
    wire [`PFS_NUM_FUNC-1:0] owner;
    wire [`PFS_NUM_FUNC-1:0] in_en;

    pad_route_decoder u_decoder (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .sel_i      (select_reg),
        .force_in_i (force_reg),
        .owner_o    (owner),
        .in_en_o    (in_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pad input synchroniser; first stage feeds only the second
    reg pad_meta_reg;
    reg pad_sync_reg;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pad_meta_reg <= 1'b0;
            pad_sync_reg <= 1'b0;
        end else begin
            pad_meta_reg <= target_pad_i;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input fan-out: a function sees the pad only while its input path is on,
    // otherwise it sees a quiet low
    wire [`PFS_NUM_FUNC-1:0] fanout_next;

    assign fanout_next = {`PFS_NUM_FUNC{pad_sync_reg}} & in_en;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gpio_bank2_line5_o      <= 1'b0;
            timer4_channel0_o       <= 1'b0;
            pdm_bitstream0_o        <= 1'b0;
            display_data1_o         <= 1'b0;
            spi7_data_in_o          <= 1'b0;
            uart6_receive_o         <= 1'b0;
            i2c6_clock_o            <= 1'b0;
            flexible_io1_channel5_o <= 1'b0;
        end else begin
            gpio_bank2_line5_o      <= fanout_next[`FUNC_GPIO_B2L5];
            timer4_channel0_o       <= fanout_next[`FUNC_TIMER4_CH0];
            pdm_bitstream0_o        <= fanout_next[`FUNC_PDM_BS0];
            display_data1_o         <= fanout_next[`FUNC_DISPLAY_D1];
            spi7_data_in_o          <= fanout_next[`FUNC_SPI7_DIN];
            uart6_receive_o         <= fanout_next[`FUNC_UART6_RX];
            i2c6_clock_o            <= fanout_next[`FUNC_I2C6_CLOCK];
            flexible_io1_channel5_o <= fanout_next[`FUNC_FLEXIO1_CH5];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output drive: only the selected function may drive the pad, so two
    // functions can never fight on it
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            target_pad_o    <= 1'b0;
            target_pad_oe_o <= 1'b0;
        end else begin
            target_pad_o    <= |(func_out_i & owner);
            target_pad_oe_o <= |(func_oe_i & owner);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state view: copies of the fields for the pad's neighbours; they move
    // one edge after the register, together with the decoder
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            active_function_o  <= `PFS_SEL_RESET;
            force_input_path_o <= `PFS_FORCE_RESET;
        end else begin
            active_function_o  <= select_reg;
            force_input_path_o <= force_reg;
        end
    end

endmodule // pad_function_select_mux

// file: test/pad_function_select_mux_asserts.sv
// Purpose: port assertions for the pad function select mux
// Assumes: one clock, synchronous reset
// Notes:   fan-out lags the select view by one edge
`timescale 1ns/1ps
module pad_function_select_mux_asserts (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    // register bus
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // pad and fan-out
    input wire logic        target_pad_i,
    input wire logic        gpio_bank2_line5_o,
    input wire logic        timer4_channel0_o,
    input wire logic        spi7_data_in_o,
    input wire logic        uart6_receive_o,
    input wire logic        flexible_io1_channel5_o,
    input wire logic [2:0]  active_function_o,
    input wire logic        force_input_path_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // a write only counts at the edge where it is answered
    wire wr_hit = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h24
        && avs_byteenable_i[0];
    a_sel_follow: assert property (wr_hit |=>
        active_function_o == $past(avs_writedata_i[2:0])) else $error("select view");
    a_force_follow: assert property (wr_hit |=>
        force_input_path_o == $past(avs_writedata_i[4])) else $error("force view");
    a_force_opens: assert property ($past(force_input_path_o) |->
        spi7_data_in_o == $past(target_pad_i, 3)) else $error("forced input");
    a_gpio_closed: assert property (!$past(force_input_path_o)
        && $past(active_function_o) != 3'h0 |-> !gpio_bank2_line5_o) else $error("gpio leak");
    a_timer_route: assert property ($past(active_function_o) == 3'h1 |->
        timer4_channel0_o == $past(target_pad_i, 3)) else $error("timer route");
    a_uart_route: assert property ($past(active_function_o) == 3'h5 |->
        uart6_receive_o == $past(target_pad_i, 3)) else $error("uart route");
    a_flex_route: assert property ($past(active_function_o) == 3'h7 |->
        flexible_io1_channel5_o == $past(target_pad_i, 3)) else $error("flex route");
    a_resv_zero: assert property (avs_read_i && !avs_waitrequest_o |->
        avs_readdata_o[31:5] == 27'h0 && !avs_readdata_o[3]) else $error("reserved bits");
endmodule // pad_function_select_mux_asserts

// file: test/tb_pad_function_select_mux.sv
// Purpose: register and routing tests for the pad function select mux
// Assumes: one 100 MHz clock, synchronous reset
// Notes:   selected function drive data low, others high, then the reverse, to catch leaks
`timescale 1ns/1ps
module tb_pad_function_select_mux;
    logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, target_pad_i;
    logic [7:0]  avs_address_i, func_out_i, func_oe_i;
    logic [31:0] avs_writedata_i, q;
    logic [3:0]  avs_byteenable_i;
    wire  [31:0] avs_readdata_o;
    wire  [2:0]  active_function_o;
    wire         avs_waitrequest_o, target_pad_o, target_pad_oe_o, force_input_path_o;
    wire         gpio_bank2_line5_o, timer4_channel0_o, pdm_bitstream0_o, display_data1_o;
    wire         spi7_data_in_o, uart6_receive_o, i2c6_clock_o, flexible_io1_channel5_o;
    wire  [7:0]  fo = {flexible_io1_channel5_o, i2c6_clock_o, uart6_receive_o, spi7_data_in_o,
        display_data1_o, pdm_bitstream0_o, timer4_channel0_o, gpio_bank2_line5_o};
    int          bad_count = 0;
    int          checks = 0;
    pad_function_select_mux dut_u (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .target_pad_i, .target_pad_o, .target_pad_oe_o, .func_out_i,
        .func_oe_i, .gpio_bank2_line5_o, .timer4_channel0_o, .pdm_bitstream0_o,
        .display_data1_o, .spi7_data_in_o, .uart6_receive_o, .i2c6_clock_o,
        .flexible_io1_channel5_o, .active_function_o, .force_input_path_o);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_i, avs_read_i, avs_write_i, target_pad_i} = 4'h8;
        {avs_address_i, func_out_i, func_oe_i, avs_byteenable_i, avs_writedata_i} = '0;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        bus(1'b0, 8'h24, 32'h0, 4'h0);
        chk("reset value", q, 32'h0);
        $display("test reset done");
        target_pad_i <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            func_oe_i <= 8'h01 << c;
            func_out_i <= ~(8'h01 << c);
            bus(1'b1, 8'h24, 32'hFFFF_FFE8 | c, 4'hF);
            bus(1'b0, 8'h24, 32'h0, 4'h0);
            chk("readback", q, c);
            chk("active view", active_function_o, c);
            chk("fan-out", fo, 8'h01 << c);
            chk("pad drive", {target_pad_oe_o, target_pad_o}, 2'b10);
            func_oe_i <= ~(8'h01 << c);
            func_out_i <= 8'h01 << c;
            repeat (2) @(posedge sys_clk_i);
            chk("pad drive swapped", {target_pad_oe_o, target_pad_o}, 2'b01);
        end
        $display("test select done");
        bus(1'b1, 8'h24, 32'h0000_0016, 4'h1);
        chk("forced fan-out", fo, 8'hFF);
        chk("force view", force_input_path_o, 1'b1);
        target_pad_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk("forced pad low", fo, 8'h00);
        target_pad_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        bus(1'b1, 8'h24, 32'h0000_0003, 4'hE);
        bus(1'b1, 8'h28, 32'h0000_0005, 4'hF);
        bus(1'b0, 8'h28, 32'h0, 4'h0);
        chk("unmapped read", q, 32'h0);
        bus(1'b0, 8'h24, 32'h0, 4'h0);
        chk("ignored writes", q, 32'h0000_0016);
        $display("test force done");
        bus(1'b1, 8'h24, 32'h0000_0006, 4'h1);
        chk("force off", fo, 8'h40);
        $display("test release done");
        wrap_up();
    end
endmodule // tb_pad_function_select_mux
bind pad_function_select_mux pad_function_select_mux_asserts chk_u (.sys_clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .target_pad_i, .gpio_bank2_line5_o,
    .timer4_channel0_o, .spi7_data_in_o, .uart6_receive_o, .flexible_io1_channel5_o,
    .active_function_o, .force_input_path_o);
